// ==== include/clock_ctl_pkg.sv ====
// constants and types for the main clock controller with time base
// assumes a single oscillator-rate clock and a classic wishbone register bus
package clock_ctl_pkg;

  // register word indices; byte address is four times the index
  localparam logic [7:0] misc_config_reg_one_index = 8'h20;
  localparam logic [7:0] clock_timebase_ctl_status_index = 8'h29;
  localparam int addr_width = 10;

  // miscellaneous config register one: field positions and reset
  localparam int misc_slow_mode_sel_bit = 0;
  localparam int misc_prescale_lsb = 1;
  localparam int misc_clock_output_enable_bit = 5;
  localparam logic [7:0] misc_config_reset = 8'h00;
  localparam logic [7:0] misc_config_write_mask = 8'h27;

  // time base control/status: field positions and reset
  localparam int tb_flag_bit = 0;
  localparam int tb_irq_enable_bit = 1;
  localparam int tb_sel_lsb = 2;
  localparam logic [7:0] tb_status_reset = 8'h01;
  localparam logic [1:0] tb_sel_reset = 2'h0;

  // time-base periods in oscillator cycles
  localparam logic [18:0] tb_period_00 = 19'd32000;
  localparam logic [18:0] tb_period_01 = 19'd64000;
  localparam logic [18:0] tb_period_10 = 19'd160000;
  localparam logic [18:0] tb_period_11 = 19'd400000;

  // cpu prescaler: normal mode divides by 2, slow mode by 4..32;
  // six bits so that the divide by 32 fits
  localparam int div_width = 6;
  localparam logic [div_width-1:0] div_normal = 6'd2;
  localparam logic [div_width-1:0] div_slow_00 = 6'd4;
  localparam logic [div_width-1:0] div_slow_10 = 6'd8;
  localparam logic [div_width-1:0] div_slow_01 = 6'd16;
  localparam logic [div_width-1:0] div_slow_11 = 6'd32;

  typedef enum logic [1:0] {run_mode, wait_mode, active_halt_mode, full_halt_mode}
    power_mode_type;

endpackage

// ==== verilog/clock_divider.sv ====
// programmable clock divider producing a 50% square wave and an enable pulse
// assumes a divisor that is even and at least 2
`timescale 1ns/1ps
`default_nettype none
module clock_divider
  #(parameter int width = 6)
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [width-1:0] divisor_i,
  output logic clk_o,
  output logic tick_o
  );

  typedef struct packed
  {
    logic [width-1:0] count;
    logic [width-1:0] divisor;
    logic level;
    logic tick;
  } state_type;

  state_type state;
  state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    if (run_i)
    begin
      // divisor is latched at wrap, so a change never leaves a runt phase;
      // the zero left by reset forces a wrap on the first running edge
      if (state.divisor == '0 || state.count >= state.divisor - width'(1))
      begin
        next_state.count = '0;
        next_state.divisor = divisor_i;
        next_state.level = 1'b1;
        next_state.tick = 1'b1;
      end
      else
      begin
        next_state.count = state.count + width'(1);
        if (state.count + width'(1) == (state.divisor >> 1))
        begin
          next_state.level = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign clk_o = state.level;
  assign tick_o = state.tick;

endmodule // clock_divider
`default_nettype wire

// ==== verilog/timebase_counter.sv ====
// periodic time-base counter; period latched at each restart
// assumes select is stable software state from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module timebase_counter
  import clock_ctl_pkg::*;
  #(parameter logic [18:0] period_00 = tb_period_00,
    parameter logic [18:0] period_01 = tb_period_01,
    parameter logic [18:0] period_10 = tb_period_10,
    parameter logic [18:0] period_11 = tb_period_11)
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  output logic elapsed_o
  );

  typedef struct packed
  {
    logic [18:0] count;
    logic [18:0] period;
    logic elapsed;
  } state_type;

  state_type state;
  state_type next_state;
  logic [18:0] chosen_period;

  always_comb
  begin
    unique case (sel_i)
      2'h0: chosen_period = period_00;
      2'h1: chosen_period = period_01;
      2'h2: chosen_period = period_10;
      2'h3: chosen_period = period_11;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_state.elapsed = 1'b0;
    if (run_i)
    begin
      if (state.count >= state.period - 19'd1)
      begin
        next_state.count = '0;
        next_state.period = chosen_period;
        next_state.elapsed = 1'b1;
      end
      else
      begin
        next_state.count = state.count + 19'd1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state.count <= '0;
      state.period <= period_00;
      state.elapsed <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign elapsed_o = state.elapsed;

endmodule // timebase_counter
`default_nettype wire

// ==== verilog/main_clock_ctl.sv ====
// main clock controller: cpu prescaler, clock output, time-base counter
// assumes clk_i is the oscillator clock; power-mode requests come from the
// core on the same clock; registers reached over classic wishbone
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module main_clock_ctl
  import clock_ctl_pkg::*;
  #(parameter logic [18:0] period_00 = tb_period_00,
    parameter logic [18:0] period_01 = tb_period_01,
    parameter logic [18:0] period_10 = tb_period_10,
    parameter logic [18:0] period_11 = tb_period_11)
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [clock_ctl_pkg::addr_width-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic core_irq_mask_i,
  input wire logic halt_request_i,
  input wire logic wait_request_i,
  input wire logic halt_exit_wake_i,
  input wire logic other_irq_i,
  output logic cpu_clk_o,
  output logic cpu_clk_tick_o,
  output logic can_clk_o,
  output logic clock_output_o,
  output logic clock_output_oe_o,
  output logic timebase_irq_o,
  output logic active_halt_o,
  output logic full_halt_o,
  output logic wait_o
  );

  typedef struct packed
  {
    logic [7:0] misc_config_reg_one;
    logic [1:0] time_base_sel;
    logic timebase_irq_enable;
    logic timebase_flag;
    power_mode_type mode;
    logic ack;
    logic [31:0] rdata;
    logic clock_output_level;
  } state_type;

  state_type state;
  state_type next_state;

  logic bus_req;
  logic hit_misc;
  logic hit_tb;
  logic tb_elapsed;
  logic regs_frozen;
  logic counter_run;
  logic [div_width-1:0] cpu_divisor;
  logic [1:0] prescale_code;
  logic [7:0] tb_status_view;
  logic slow_mode;
  logic output_on;
  logic write_ok;
  logic read_status;
  logic tb_wake;
  logic wait_wake;

  assign bus_req = wb_cyc_i & wb_stb_i & ~state.ack;
  assign hit_misc = wb_adr_i == {misc_config_reg_one_index, 2'b00};
  assign hit_tb = wb_adr_i == {clock_timebase_ctl_status_index, 2'b00};

  // registers hold while halted; the counter only runs outside full halt
  assign regs_frozen = state.mode == active_halt_mode || state.mode == full_halt_mode;
  assign counter_run = state.mode != full_halt_mode;

  // writes are dropped while frozen but still acked, so the core never stalls
  assign write_ok = bus_req & wb_we_i & wb_sel_i[0] & ~regs_frozen;
  // the clearing read is refused while frozen as well, so halts keep the flag
  assign read_status = bus_req & ~wb_we_i & hit_tb & ~regs_frozen;
  // a period end only counts as a wake source when the enable is set
  assign tb_wake = tb_elapsed & state.timebase_irq_enable;
  // wait is left on any unmasked request; masked ones keep the core asleep
  assign wait_wake = timebase_irq_o | other_irq_i;

  assign slow_mode = state.misc_config_reg_one[misc_slow_mode_sel_bit];
  assign prescale_code = state.misc_config_reg_one[misc_prescale_lsb +: 2];
  assign output_on = state.misc_config_reg_one[misc_clock_output_enable_bit];

  always_comb
  begin
    if (!slow_mode)
    begin
      cpu_divisor = div_normal;
    end
    else
    begin
      // code is {bit2, bit1}; the two middle codes are not in divide order
      unique case (prescale_code)
        2'h0: cpu_divisor = div_slow_00;
        2'h1: cpu_divisor = div_slow_01;
        2'h2: cpu_divisor = div_slow_10;
        2'h3: cpu_divisor = div_slow_11;
      endcase
    end
  end

  // bits 7:4 tie to zero
  always_comb
  begin
    tb_status_view = '0;
    tb_status_view[tb_sel_lsb +: 2] = state.time_base_sel;
    tb_status_view[tb_irq_enable_bit] = state.timebase_irq_enable;
    tb_status_view[tb_flag_bit] = state.timebase_flag;
  end

  // cpu clock stops in either halt; divider keeps its phase meanwhile
  clock_divider #(.width(div_width)) cpu_prescaler
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(~regs_frozen),
    .divisor_i(cpu_divisor),
    .clk_o(cpu_clk_o),
    .tick_o(cpu_clk_tick_o)
  );

  // separate counter so the prescaler never reaches the can clock
  clock_divider #(.width(div_width)) can_divider
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .divisor_i(div_normal),
    .clk_o(can_clk_o),
    .tick_o()
  );

  timebase_counter #(
    .period_00(period_00),
    .period_01(period_01),
    .period_10(period_10),
    .period_11(period_11)
  ) time_base
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(counter_run),
    .sel_i(state.time_base_sel),
    .elapsed_o(tb_elapsed)
  );

  always_comb
  begin
    next_state = state;
    next_state.ack = bus_req;

    // clock output toggles every oscillator cycle while enabled, unless in active or full halt
    if (output_on && state.mode != active_halt_mode && state.mode != full_halt_mode)
    begin
      next_state.clock_output_level = ~state.clock_output_level;
    end

    if (bus_req)
    begin
      next_state.rdata = '0;
      if (hit_misc)
      begin
        next_state.rdata[7:0] = state.misc_config_reg_one;
      end
      else if (hit_tb)
      begin
        next_state.rdata[7:0] = tb_status_view;
      end
    end

    // writes are gated by write_ok, so no bus access in halt reaches frozen registers
    if (write_ok)
    begin
      if (hit_misc)
      begin
        next_state.misc_config_reg_one = wb_dat_i[7:0] & misc_config_write_mask;
      end
      if (hit_tb)
      begin
        next_state.time_base_sel = wb_dat_i[tb_sel_lsb +: 2];
        next_state.timebase_irq_enable = wb_dat_i[tb_irq_enable_bit];
      end
    end

    // read clears the flag, but a period end in the same cycle wins
    if (read_status)
    begin
      next_state.timebase_flag = 1'b0;
    end
    if (tb_elapsed)
    begin
      next_state.timebase_flag = 1'b1;
    end

    unique case (state.mode)
      run_mode:
      begin
        if (halt_request_i)
        begin
          if (state.timebase_irq_enable)
          begin
            next_state.mode = active_halt_mode;
          end
          else
          begin
            next_state.mode = full_halt_mode;
          end
        end
        else if (wait_request_i)
        begin
          next_state.mode = wait_mode;
        end
      end
      wait_mode:
      begin
        if (wait_wake)
        begin
          next_state.mode = run_mode;
        end
      end
      active_halt_mode:
      begin
        if (tb_wake || halt_exit_wake_i)
        begin
          next_state.mode = run_mode;
        end
      end
      full_halt_mode:
      begin
        if (halt_exit_wake_i)
        begin
          next_state.mode = run_mode;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state.misc_config_reg_one <= misc_config_reset;
      state.time_base_sel <= tb_status_reset[tb_sel_lsb +: 2];
      state.timebase_irq_enable <= tb_status_reset[tb_irq_enable_bit];
      state.timebase_flag <= tb_status_reset[tb_flag_bit];
      state.mode <= run_mode;
      state.ack <= 1'b0;
      state.rdata <= '0;
      state.clock_output_level <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.rdata;
  assign clock_output_o = state.clock_output_level;
  assign clock_output_oe_o = output_on;
  // a period end with the enable set wakes active halt; mask only gates the core request
  assign timebase_irq_o = state.timebase_flag & state.timebase_irq_enable
    & ~core_irq_mask_i;
  assign active_halt_o = state.mode == active_halt_mode;
  assign full_halt_o = state.mode == full_halt_mode;
  assign wait_o = state.mode == wait_mode;

endmodule // main_clock_ctl
`default_nettype wire

// ==== test/clock_ctl_asserts.sv ====
// port assertions for the main clock controller
// assumes it is bound to main_clock_ctl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module clock_ctl_asserts
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [clock_ctl_pkg::addr_width-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_irq_mask_i,
  input wire logic halt_request_i,
  input wire logic halt_exit_wake_i,
  input wire logic can_clk_o,
  input wire logic cpu_clk_o,
  input wire logic clock_output_o,
  input wire logic clock_output_oe_o,
  input wire logic timebase_irq_o,
  input wire logic active_halt_o,
  input wire logic full_halt_o,
  input wire logic wait_o
  );
  import clock_ctl_pkg::*;
  logic live;
  logic warm;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // first two edges after reset have no valid history for the clocks
  always_ff @(posedge clk_i)
  begin
    warm <= !rst_i;
    live <= warm && !rst_i;
  end
  sequence s_out_run;
    (clock_output_oe_o && !active_halt_o && !full_halt_o) [*3];
  endsequence
  sequence s_halted;
    (active_halt_o || full_halt_o) [*3];
  endsequence
  property p_can; live |-> can_clk_o != $past(can_clk_o); endproperty
  property p_out_run; s_out_run |-> clock_output_o != $past(clock_output_o); endproperty
  property p_out_stop; active_halt_o [*3] |-> $stable(clock_output_o); endproperty
  property p_cpu_stop; s_halted |-> $stable(cpu_clk_o); endproperty
  property p_masked; core_irq_mask_i |-> !timebase_irq_o; endproperty
  property p_hi_zero;
    wb_ack_o && wb_adr_i == {clock_timebase_ctl_status_index, 2'b00} |-> wb_dat_o[31:4] == 28'h0;
  endproperty
  property p_enter;
    halt_request_i && !active_halt_o && !full_halt_o && !wait_o |=> active_halt_o || full_halt_o;
  endproperty
  property p_full_hold; full_halt_o && !halt_exit_wake_i |=> full_halt_o; endproperty
  a_can: assert property (p_can) else $error("can clock not toggling");
  a_out_run: assert property (p_out_run) else $error("clock out not toggling");
  a_out_stop: assert property (p_out_stop) else $error("clock out runs in halt");
  a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clock runs in halt");
  a_masked: assert property (p_masked) else $error("irq while masked");
  a_hi_zero: assert property (p_hi_zero) else $error("status high bits set");
  a_enter: assert property (p_enter) else $error("halt not entered");
  a_full_hold: assert property (p_full_hold) else $error("full halt left early");
endmodule // clock_ctl_asserts
bind main_clock_ctl clock_ctl_asserts u_chk (.*);
`default_nettype wire

// ==== test/core_model.sv ====
// core side: turns halt and wait commands into requests one cycle later
// assumes commands come from the bench on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module core_model
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_cmd_i,
  input wire logic wait_cmd_i,
  output logic halt_request_o,
  output logic wait_request_o
  );
  always_ff @(posedge clk_i)
  begin
    halt_request_o <= halt_cmd_i && !rst_i;
    wait_request_o <= wait_cmd_i && !rst_i;
  end
endmodule // core_model
`default_nettype wire

// ==== test/test_main_clock_ctl.sv ====
// bench for main_clock_ctl with shortened time-base periods
// assumes the checker is bound and core_model stands for the core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_main_clock_ctl;
  import clock_ctl_pkg::*;
  localparam logic [9:0] misc_a = {misc_config_reg_one_index, 2'b00};
  localparam logic [9:0] st_a = {clock_timebase_ctl_status_index, 2'b00};
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h1, pls = 4'h0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rnd = 32'h4b529fd9;
  logic wb_ack_o, core_irq_mask_i = 1'b0, halt_request_i, wait_request_i, irq_q = 1'b0;
  logic cpu_clk_o, cpu_clk_tick_o, can_clk_o, clock_output_o, clock_output_oe_o;
  logic timebase_irq_o, active_halt_o, full_halt_o, wait_o;
  logic [7:0] exp_q[$], e8, exp_rd;
  wire halt_exit_wake_i = pls[2];
  wire other_irq_i = pls[3];
  int fails = 0, samples_checked = 0, now = 0, rise_t = 0, last_t = 0, n;
  int ps_d[5] = '{2, 4, 8, 16, 32}, tb_p[4] = '{20, 40, 100, 250};
  logic [7:0] ps_w[5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
  always #5 clk_i = ~clk_i;
  main_clock_ctl #(.period_00(19'd20), .period_01(19'd40), .period_10(19'd100),
    .period_11(19'd250)) DUT (.*);
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .halt_cmd_i(pls[0]), .wait_cmd_i(pls[1]),
    .halt_request_o(halt_request_i), .wait_request_o(wait_request_i));
  always @(posedge clk_i)
  begin
    now <= now + 1;
    irq_q <= timebase_irq_o;
    if (timebase_irq_o && !irq_q)
      rise_t <= now;
    if (wb_ack_o && !wb_we_i)
    begin
      exp_rd = exp_q.pop_front();
      `CHK("read data", {24'h0, exp_rd}, wb_dat_o)
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // a read takes d as the expected byte
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
    int t;
    t = 0;
    if (!we)
      exp_q.push_back(d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= we ? {24'h0, d} : 32'h0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    `CHK("ack", 1'b1, wb_ack_o)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic tick_gap(output int c);
    int t[3];
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      while (cpu_clk_tick_o !== 1'b1)
        @(posedge clk_i);
      t[k] = now;
    end
    c = t[2] - t[1];
  endtask
  task automatic wait_rise(output int p);
    int old;
    old = rise_t;
    while (rise_t == old)
      @(posedge clk_i);
    p = rise_t - last_t;
    last_t = rise_t;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    pls <= m;
    @(posedge clk_i);
    pls <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    finish_test();
  end
  // status is only read or written whole, never read-modify-write
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, st_a, tb_status_reset);
    wb(0, st_a, 8'h00);
    wb(0, misc_a, misc_config_reset);
    wb(0, 10'h3fc, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      rnd = xs(rnd);
      wb(1, misc_a, rnd[7:0]);
      wb(0, misc_a, rnd[7:0] & misc_config_write_mask);
    end
    foreach (ps_w[k])
    begin
      wb(1, misc_a, ps_w[k]);
      tick_gap(n);
      `CHK("cpu divide", ps_d[k], n)
    end
    wb(1, misc_a, 8'h20);
    `CHK("clock out enable", 1'b1, clock_output_oe_o)
    wb(1, st_a, 8'h02);
    wb(0, st_a, 8'h03);
    wait_rise(n);
    for (int k = 1; k < 5; k++)
    begin
      e8 = {4'h0, 2'(k > 3 ? 3 : k), 2'b10};
      wb(1, st_a, e8);
      wb(0, st_a, e8 | 8'h01);
      wait_rise(n);
      `CHK("period", tb_p[k - 1], n)
    end
    core_irq_mask_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, timebase_irq_o)
    core_irq_mask_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("irq on", 1'b1, timebase_irq_o)
    pulse(4'h1);
    `CHK("active halt", 1'b1, active_halt_o)
    for (n = 0; n < 300 && active_halt_o; n++)
      @(posedge clk_i);
    `CHK("active halt end", 1'b0, active_halt_o)
    wb(1, st_a, 8'h0c);
    pulse(4'h1);
    `CHK("full halt", 1'b1, full_halt_o)
    repeat (300) @(posedge clk_i);
    `CHK("full halt kept", 1'b1, full_halt_o)
    pulse(4'h4);
    `CHK("full halt end", 1'b0, full_halt_o)
    pulse(4'h2);
    `CHK("wait", 1'b1, wait_o)
    pulse(4'h8);
    `CHK("wait end", 1'b0, wait_o)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, st_a, tb_status_reset);
    wb(0, misc_a, misc_config_reset);
    finish_test();
  end
endmodule // test_main_clock_ctl
`default_nettype wire
